/* src/slc_map.svh */
`ifndef SLC_MAP_SVH
`define SLC_MAP_SVH
// register byte offsets
`define SLC_QUAD_CTL_OFF      12'h000
`define SLC_TXL0_OFF          12'h004
`define SLC_STATUS_OFF        12'h008
// quad control fields
`define SLC_LANE_TARGET_SELECT_LSB       0
`define SLC_LANE_TARGET_SELECT_MSB       4
`define SLC_SLEEP_BIT         5
`define SLC_LANE_TARGET_SELECT_RESET     5'h10
`define SLC_LANE_TARGET_SELECT_ALL       5'h10
`define SLC_LANE_TARGET_SELECT_MAXONE    5'h03
// tx lane control fields
`define SLC_CDG1_LSB          0
`define SLC_CDG2L_LSB         2
`define SLC_CDG2H_LSB         4
`define SLC_TXEQ1_LSB         8
`define SLC_TXL0_MASK         32'h0000_033f
`define SLC_TXL0_RESET        32'h0000_0237
`define SLC_QUAD_MASK         32'h0000_003f
`endif

/* src/slc_pkg.sv */
package slc_pkg;
   typedef enum logic [1:0] {
      SLC_PWR_UP    = 2'b00,
      SLC_PWR_DOWN  = 2'b01,
      SLC_PWR_INIT  = 2'b10
   } slc_pwr_t;
   typedef logic [1:0] slc_field_t;
endpackage

/* src/slc_serdes_lane_control_regs.sv */
`timescale 1ns/1ps
`include "slc_map.svh"
// Summary of operation
// - a lane control write updates only the lane picked by lane-target (0..3) or all four for 0x10, which resets to 0x10.
// - a lane control read ignores lane-target and returns the last value written.
// - setting quad sleep puts all lanes into P2 and powers down the clock multiplier unit.
// - setting quad sleep sends each port's link state machine to Detect at once.
// - clearing quad sleep powers up and initializes the quad, then link training starts.
// - quad sleep has no effect when the quad is already down for another reason, except during initialization, where it still powers the quad down.
// - bits 1:0 hold gen1 coarse de-emphasis, reset 0x3.
// - bits 3:2 hold gen2 light coarse de-emphasis, reset 0x1.
// - bits 5:4 hold gen2 heavy coarse de-emphasis, reset 0x3.
// - coarse de-emphasis has no effect in low-swing mode.
// - bits 9:8 hold gen1 transmit equalization, reset 0x2, values 0x0 to 0x3.
// - every lane copy of the transmit fields is soft sticky, selected or not.
module slc_serdes_lane_control_regs (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // port status
   input  wire logic        port_disabled,
   input  wire logic        low_swing,
   input  wire logic        deemph_level_select,
   input  wire logic        gen2_rate,
   input  wire logic        init_done,
   // serdes control
   output logic [3:0]       lane_p2,
   output logic             clock_multiplier_unit_off,
   output logic             force_detect,
   output logic             start_training,
   output logic [7:0]       lane_deemph,
   output logic [7:0]       lane_tx_equalize
);
   logic [4:0]               lane_target_select_reg;
   logic                     quad_sleep_reg;
   logic [31:0]              txl0_last_reg;
   logic [3:0][9:0]          lane_reg;
   slc_pkg::slc_pwr_t        pwr_reg;
   slc_pkg::slc_pwr_t        pwr_next;
   logic                     dis_s1_reg;
   logic                     dis_s2_reg;
   logic                     init_s1_reg;
   logic                     init_s2_reg;
   logic                     start_training_reg;
   logic                     wr_en;
   logic                     access;
   logic                     sleep_set;

   function automatic logic lane_hit(input logic [4:0] sel, input int idx);
      lane_hit = (sel == `SLC_LANE_TARGET_SELECT_ALL) || (sel == 5'(idx));
   endfunction

   assign access    = psel & penable & clk_en;
   assign wr_en     = access & pwrite;
   assign pready    = 1'b1;
   assign pslverr   = 1'b0;
   assign sleep_set = wr_en && paddr == `SLC_QUAD_CTL_OFF && pwdata[`SLC_SLEEP_BIT];

   // pin synchronisers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dis_s1_reg  <= 1'b0;
         dis_s2_reg  <= 1'b0;
         init_s1_reg <= 1'b0;
         init_s2_reg <= 1'b0;
      end else if (clk_en) begin
         dis_s1_reg  <= port_disabled;
         dis_s2_reg  <= dis_s1_reg;
         init_s1_reg <= init_done;
         init_s2_reg <= init_s1_reg;
      end
   end

   // quad control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_target_select_reg <= `SLC_LANE_TARGET_SELECT_RESET;
         quad_sleep_reg         <= 1'b0;
      end else if (wr_en && paddr == `SLC_QUAD_CTL_OFF) begin
         lane_target_select_reg <= pwdata[`SLC_LANE_TARGET_SELECT_MSB:`SLC_LANE_TARGET_SELECT_LSB];
         quad_sleep_reg         <= pwdata[`SLC_SLEEP_BIT];
      end
   end

   // per-lane transmit control copies
   generate
      for (genvar i = 0; i < 4; i++) begin : g_lane
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               lane_reg[i] <= 10'(`SLC_TXL0_RESET);
            end else if (wr_en && paddr == `SLC_TXL0_OFF &&
                         lane_hit(lane_target_select_reg, i)) begin
               lane_reg[i] <= pwdata[9:0] & 10'(`SLC_TXL0_MASK);
            end
         end
         always_comb begin
            if (low_swing) begin
               lane_deemph[2*i +: 2] = 2'h0;
            end else if (!gen2_rate) begin
               lane_deemph[2*i +: 2] = lane_reg[i][`SLC_CDG1_LSB +: 2];
            end else if (deemph_level_select) begin
               lane_deemph[2*i +: 2] = lane_reg[i][`SLC_CDG2L_LSB +: 2];
            end else begin
               lane_deemph[2*i +: 2] = lane_reg[i][`SLC_CDG2H_LSB +: 2];
            end
         end
         assign lane_tx_equalize[2*i +: 2] = lane_reg[i][`SLC_TXEQ1_LSB +: 2];
         assign lane_p2[i] = (pwr_reg == slc_pkg::SLC_PWR_DOWN);

         property p_lane_copy;
            @(posedge pclk) disable iff (!presetn)
               (wr_en && paddr == `SLC_TXL0_OFF && lane_hit(lane_target_select_reg, i))
               |=> lane_reg[i] == ($past(pwdata[9:0]) & 10'(`SLC_TXL0_MASK));
         endproperty
         a_lane_copy: assert property (p_lane_copy) else $error("copy wrong");

         property p_lane_stay;
            @(posedge pclk) disable iff (!presetn)
               !(wr_en && paddr == `SLC_TXL0_OFF && lane_hit(lane_target_select_reg, i))
               |=> $stable(lane_reg[i]);
         endproperty
         a_lane_stay: assert property (p_lane_stay) else $error("copy lost");

         property p_lane_reset;
            @(posedge pclk) disable iff (!presetn)
               $rose(presetn) |-> lane_reg[i] == 10'(`SLC_TXL0_RESET);
         endproperty
         a_lane_reset: assert property (p_lane_reset) else $error("copy reset");
      end
   endgenerate

   // last written lane control value for readback
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txl0_last_reg <= `SLC_TXL0_RESET;
      end else if (wr_en && paddr == `SLC_TXL0_OFF) begin
         txl0_last_reg <= pwdata & `SLC_TXL0_MASK;
      end
   end

   // power state machine
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         slc_pkg::SLC_PWR_UP: begin
            if (quad_sleep_reg && !dis_s2_reg) begin
               pwr_next = slc_pkg::SLC_PWR_DOWN;
            end
         end
         slc_pkg::SLC_PWR_DOWN: begin
            if (!quad_sleep_reg && !dis_s2_reg) begin
               pwr_next = slc_pkg::SLC_PWR_INIT;
            end
         end
         slc_pkg::SLC_PWR_INIT: begin
            if (quad_sleep_reg) begin
               pwr_next = slc_pkg::SLC_PWR_DOWN;
            end else if (init_s2_reg) begin
               pwr_next = slc_pkg::SLC_PWR_UP;
            end
         end
         default: pwr_next = slc_pkg::SLC_PWR_DOWN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_reg            <= slc_pkg::SLC_PWR_UP;
         start_training_reg <= 1'b0;
      end else if (clk_en) begin
         pwr_reg            <= pwr_next;
         start_training_reg <= (pwr_reg == slc_pkg::SLC_PWR_INIT) &&
                               (pwr_next == slc_pkg::SLC_PWR_UP);
      end
   end

   assign clock_multiplier_unit_off = (pwr_reg == slc_pkg::SLC_PWR_DOWN);
   // detect forced by the sleep state, or at once on the write; ignored if port down
   assign force_detect   = !dis_s2_reg && (quad_sleep_reg || sleep_set);
   assign start_training = start_training_reg;

   // read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (clk_en && psel && !penable && !pwrite) begin
         unique case (paddr)
            `SLC_QUAD_CTL_OFF: prdata <= {26'h000_0000, quad_sleep_reg, lane_target_select_reg};
            `SLC_TXL0_OFF:     prdata <= txl0_last_reg;
            `SLC_STATUS_OFF:   prdata <= {30'h0000_0000, pwr_reg};
            default:           prdata <= 32'h0000_0000;
         endcase
      end
   end

   property p_sleep_detect;
      @(posedge pclk) disable iff (!presetn)
         (sleep_set && !dis_s2_reg) |-> force_detect ##1 quad_sleep_reg;
   endproperty
   a_sleep_detect: assert property (p_sleep_detect) else $error("detect not forced");

   property p_reset_lane;
      @(posedge pclk) disable iff (!presetn)
         $rose(presetn) |-> lane_target_select_reg == `SLC_LANE_TARGET_SELECT_RESET;
   endproperty
   a_reset_lane: assert property (p_reset_lane) else $error("lane target bad");

   property p_lane_keep;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && !lane_hit(lane_target_select_reg, 1)) |=> $stable(lane_reg[1]);
   endproperty
   a_lane_keep: assert property (p_lane_keep) else $error("unselected lane changed");

   property p_lane_all;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && paddr == `SLC_TXL0_OFF && lane_target_select_reg == `SLC_LANE_TARGET_SELECT_ALL)
         |=> lane_reg[3] == lane_reg[0];
   endproperty
   a_lane_all: assert property (p_lane_all) else $error("broadcast missed");

   property p_readback;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && paddr == `SLC_TXL0_OFF)
         |=> txl0_last_reg == ($past(pwdata) & `SLC_TXL0_MASK);
   endproperty
   a_readback: assert property (p_readback) else $error("readback wrong");

   property p_p2;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && pwr_reg == slc_pkg::SLC_PWR_UP && quad_sleep_reg && !dis_s2_reg)
         |=> (lane_p2 == 4'hf) && clock_multiplier_unit_off;
   endproperty
   a_p2: assert property (p_p2) else $error("p2 not entered");

   property p_disabled;
      @(posedge pclk) disable iff (!presetn)
         dis_s2_reg |-> !force_detect;
   endproperty
   a_disabled: assert property (p_disabled) else $error("sleep acted on down port");

   property p_lowswing;
      @(posedge pclk) disable iff (!presetn)
         low_swing |-> lane_deemph == 8'h00;
   endproperty
   a_lowswing: assert property (p_lowswing) else $error("deemph in low swing");

   property p_reserved;
      @(posedge pclk) disable iff (!presetn)
         (txl0_last_reg & ~`SLC_TXL0_MASK) == 32'h0000_0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_qctl_write;
      @(posedge pclk) disable iff (!presetn)
         (wr_en && paddr == `SLC_QUAD_CTL_OFF)
         |=> lane_target_select_reg == $past(pwdata[`SLC_LANE_TARGET_SELECT_MSB:`SLC_LANE_TARGET_SELECT_LSB])
             && quad_sleep_reg == $past(pwdata[`SLC_SLEEP_BIT]);
   endproperty
   a_qctl_write: assert property (p_qctl_write) else $error("quad control not stored");

   property p_rd_txl0;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && psel && !penable && !pwrite && paddr == `SLC_TXL0_OFF)
         |=> prdata == $past(txl0_last_reg);
   endproperty
   a_rd_txl0: assert property (p_rd_txl0) else $error("lane read wrong");

   property p_rd_quad;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && psel && !penable && !pwrite && paddr == `SLC_QUAD_CTL_OFF)
         |=> prdata == {26'h000_0000, $past(quad_sleep_reg), $past(lane_target_select_reg)};
   endproperty
   a_rd_quad: assert property (p_rd_quad) else $error("quad read wrong");

   property p_disabled_hold;
      @(posedge pclk) disable iff (!presetn)
         (dis_s2_reg && pwr_reg != slc_pkg::SLC_PWR_INIT) |=> $stable(pwr_reg);
   endproperty
   a_disabled_hold: assert property (p_disabled_hold) else $error("down port moved");

   property p_wake;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && pwr_reg == slc_pkg::SLC_PWR_DOWN && !quad_sleep_reg && !dis_s2_reg)
         |=> pwr_reg == slc_pkg::SLC_PWR_INIT && lane_p2 == 4'h0 && !clock_multiplier_unit_off;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not started");

   property p_init_done;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && pwr_reg == slc_pkg::SLC_PWR_INIT && !quad_sleep_reg && init_s2_reg)
         |=> pwr_reg == slc_pkg::SLC_PWR_UP && start_training;
   endproperty
   a_init_done: assert property (p_init_done) else $error("training not started");

   property p_sleep_in_init;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && pwr_reg == slc_pkg::SLC_PWR_INIT && quad_sleep_reg)
         |=> lane_p2 == 4'hf;
   endproperty
   a_sleep_in_init: assert property (p_sleep_in_init) else $error("sleep lost in init");

   property p_train_pulse;
      @(posedge pclk) disable iff (!presetn)
         (clk_en && start_training) |=> !start_training;
   endproperty
   a_train_pulse: assert property (p_train_pulse) else $error("training pulse too long");

   property p_freeze;
      @(posedge pclk) disable iff (!presetn)
         !clk_en |=> $stable(lane_target_select_reg) && $stable(quad_sleep_reg) &&
                     $stable(pwr_reg) && $stable(prdata) && $stable(txl0_last_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

/* tb/slc_serdes_lane_control_regs_tb_top.sv */
`timescale 1ns/1ps
`include "slc_map.svh"
module slc_serdes_lane_control_regs_tb_top;
   logic        pclk = 0, presetn = 0, clk_en = 1;
   logic        psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic        pready, pslverr;
   logic        port_disabled = 0, low_swing = 0, deemph_level_select = 0;
   logic        gen2_rate = 0, init_done = 0;
   logic [3:0]  lane_p2;
   logic        cmu_off, force_detect, start_training;
   logic [7:0]  lane_deemph, lane_tx_equalize;
   int          bad_count = 0, n_compared = 0, k;
   logic [7:0]  mode_exp [4] = '{8'h55, 8'haa, 8'hff, 8'h00};

   always #2 pclk = ~pclk;

   slc_serdes_lane_control_regs dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .port_disabled(port_disabled),
      .low_swing(low_swing), .deemph_level_select(deemph_level_select),
      .gen2_rate(gen2_rate), .init_done(init_done), .lane_p2(lane_p2),
      .clock_multiplier_unit_off(cmu_off), .force_detect(force_detect),
      .start_training(start_training), .lane_deemph(lane_deemph),
      .lane_tx_equalize(lane_tx_equalize));

   task wrap_up();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask

   // one apb transfer; returns 1 ns after the completing edge so outputs are settled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         bad_count++;
         wrap_up();
      end
      rd = prdata;
      psel <= 0; penable <= 0;
      #1;
   endtask

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, `SLC_QUAD_CTL_OFF, 0); chk(rd, 32'h0000_0010);
      apb(0, `SLC_TXL0_OFF, 0); chk(rd, 32'h0000_0237);
      chk(lane_deemph, 8'hff); chk(lane_tx_equalize, 8'haa);
      $display("reset values done");
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0002);
      apb(1, `SLC_TXL0_OFF, 32'h0000_0300);
      apb(0, `SLC_TXL0_OFF, 0); chk(rd, 32'h0000_0300);
      chk(lane_deemph, 8'hcf); chk(lane_tx_equalize, 8'hba);
      apb(0, `SLC_QUAD_CTL_OFF, 0); chk(rd, 32'h0000_0002);
      $display("single lane done");
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0010);
      apb(1, `SLC_TXL0_OFF, 32'h0000_0139);
      chk(lane_tx_equalize, 8'h55);
      for (k = 0; k < 4; k++) begin
         @(posedge pclk);
         gen2_rate <= (k == 1 || k == 2); deemph_level_select <= (k == 1);
         low_swing <= (k == 3);
         #1;
         chk(lane_deemph, mode_exp[k]);
      end
      @(posedge pclk);
      low_swing <= 0; gen2_rate <= 0;
      $display("modes done");
      apb(1, `SLC_TXL0_OFF, 32'hffff_ffff);
      apb(0, `SLC_TXL0_OFF, 0); chk(rd, 32'h0000_033f);
      apb(0, 12'h00c, 0); chk(rd, 32'h0000_0000);
      chk(pslverr, 1'b0);
      $display("reserved done");
      @(posedge pclk);
      clk_en <= 0;
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0021);
      @(posedge pclk);
      clk_en <= 1;
      apb(0, `SLC_QUAD_CTL_OFF, 0); chk(rd, 32'h0000_0010);
      chk(lane_p2, 4'h0); chk(force_detect, 1'b0);
      $display("clock enable done");
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0030);
      chk(force_detect, 1'b1);
      @(posedge pclk);
      #1;
      chk(lane_p2, 4'hf); chk(cmu_off, 1'b1);
      apb(0, `SLC_STATUS_OFF, 0); chk(rd, 32'h0000_0001);
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0010);
      apb(0, `SLC_STATUS_OFF, 0); chk(rd, 32'h0000_0002);
      @(posedge pclk);
      init_done <= 1;
      for (k = 0; k < 20; k++) begin
         @(negedge pclk);
         if (start_training === 1'b1) break;
      end
      chk(k < 20, 1'b1); chk(lane_p2, 4'h0); chk(cmu_off, 1'b0);
      if (k == 20) wrap_up();
      $display("sleep done");
      @(posedge pclk);
      init_done <= 0; port_disabled <= 1;
      repeat (3) @(posedge pclk);
      apb(1, `SLC_QUAD_CTL_OFF, 32'h0000_0030);
      chk(force_detect, 1'b0);
      repeat (2) @(posedge pclk);
      #1;
      chk(lane_p2, 4'h0); chk(cmu_off, 1'b0);
      $display("disabled port done");
      wrap_up();
   end
endmodule
